// ---- hw/snprw_defs.svh ----
`ifndef SNPRW_DEFS_SVH
`define SNPRW_DEFS_SVH

// Clocks from external address strobe to snoop answer
`define SNPRW_SNOOP_DELAY     2
// Transfers in one line (16 bytes of 4-byte words)
`define SNPRW_LINE_BEATS      4
`define SNPRW_LINE_BYTES      16
`define SNPRW_ADDR_W          32
`define SNPRW_DATA_W          32

`endif

// ---- hw/snprw_pkg.sv ----
package snprw_pkg;
  typedef logic [31:0] snprw_word_t;
  typedef enum logic [4:0] {
    SNPRW_IDLE  = 5'h01,
    SNPRW_ADDR  = 5'h02,
    SNPRW_DATA  = 5'h04,
    SNPRW_NEXT  = 5'h08,
    SNPRW_DONE  = 5'h10
  } snprw_state_e;
endpackage

// ---- hw/snprw_bus_if.sv ----
`timescale 1ns/1ps
interface snprw_bus_if;
  // System inputs (snoop, hold, backoff, ready, straps, read data), driven by the system side
  logic        external_addr_strobe_n;
  logic [31:0] snoop_addr;
  logic        address_hold;
  logic        bus_hold;
  logic        backoff_n;
  logic        burst_ready_n;
  logic        ready_n;
  logic        burst_writeback_select_n;
  logic        writeback_mode_select;
  logic [31:0] read_data;
  // Device outputs, each floatable one with its enable
  logic        snoop_hit_n;
  logic        snoop_match_dirty_n;
  logic        hold_acknowledge;
  logic        bus_request_out;
  logic        address_strobe_n;
  logic        address_strobe_oe;
  logic        last_transfer_n;
  logic        last_transfer_oe;
  logic        cache_cycle_n;
  logic        cache_cycle_oe;
  logic        write_n_read;
  logic        pseudo_lock_n;
  logic        page_uncached_attr;
  logic        page_writethrough_attr;
  logic [3:0]  byte_enables_n;
  logic        ctrl_oe;
  logic [29:0] upper_address;
  logic [1:0]  low_address_bits;
  logic        low_address_oe;
  logic [31:0] write_data;

  modport device (
    input  external_addr_strobe_n, snoop_addr, address_hold, bus_hold, backoff_n,
           burst_ready_n, ready_n, burst_writeback_select_n, writeback_mode_select, read_data,
    output snoop_hit_n, snoop_match_dirty_n, hold_acknowledge, bus_request_out,
           address_strobe_n, address_strobe_oe, last_transfer_n, last_transfer_oe,
           cache_cycle_n, cache_cycle_oe, write_n_read, pseudo_lock_n, page_uncached_attr,
           page_writethrough_attr, byte_enables_n, ctrl_oe, upper_address,
           low_address_bits, low_address_oe, write_data
  );
  modport system (
    output external_addr_strobe_n, snoop_addr, address_hold, bus_hold, backoff_n,
           burst_ready_n, ready_n, burst_writeback_select_n, writeback_mode_select, read_data,
    input  snoop_hit_n, snoop_match_dirty_n, hold_acknowledge, bus_request_out,
           address_strobe_n, address_strobe_oe, last_transfer_n, last_transfer_oe,
           cache_cycle_n, cache_cycle_oe, write_n_read, pseudo_lock_n, page_uncached_attr,
           page_writethrough_attr, byte_enables_n, ctrl_oe, upper_address,
           low_address_bits, low_address_oe, write_data
  );
endinterface

// ---- hw/snprw_device.sv ----
// Behaviour
// - Snoop hit asserts two clocks after strobe
// - Snoop miss negates hit two clocks after
// - Hit output changes only on snoops
// - Dirty hit asserts, releases after writeback
// - Dirty flag off before next address strobe
// - Invalidate may pulse dirty without writeback
// - System blocks masters while dirty asserted
// - Select high: four single writes
// - Select low: one 16-byte burst
// - System straps burst select fixed
// - Write-through mode ignores burst select
// - Cache indicator valid strobe to ready
// - Uncached-low unlocked reads assert cache indicator
// - Cacheable unlocked reads and their fills assert indicator
// - Writes assert indicator only for writebacks
// - Strobe, write, cache mark replacement writeback
// - Plus dirty flag marks snoop writeback
// - Float control outputs in hold, backoff
// - Float low address in address hold too
// - Mode select sampled at reset release
`timescale 1ns/1ps
`include "snprw_defs.svh"
module snprw_device #(
  parameter int LINES = 4
) (
  input  wire logic               CLK,
  input  wire logic               RESETN,
  snprw_bus_if.device             BUS,
  input  wire logic               INVALIDATE_REQ,
  input  wire logic               REPLACE_REQ,
  input  wire snprw_pkg::snprw_word_t REPLACE_ADDR,
  input  wire logic               READ_REQ,
  input  wire snprw_pkg::snprw_word_t READ_ADDR,
  input  wire logic               READ_UNCACHED,
  input  wire logic               READ_LOCKED,
  output logic                    REQ_READY,
  output logic                    WRITEBACK_MODE,
  output snprw_pkg::snprw_word_t  READ_DATA
);
  import snprw_pkg::*;

  localparam int IW = $clog2(LINES);

  // Line store: tag, valid and dirty per entry, words per beat
  logic [LINES-1:0]   line_valid;
  logic [LINES-1:0]   line_dirty;
  snprw_word_t        line_tag [LINES];
  snprw_word_t        line_word [LINES][`SNPRW_LINE_BEATS];

  snprw_state_e       state;
  snprw_state_e       next_state;
  logic [1:0]         beat;
  logic               burst_mode;
  logic               wb_active;
  logic               wb_snoop;
  logic               rd_active;
  logic               rd_uncached;
  logic               rd_locked;
  snprw_word_t        cyc_addr;
  logic [IW-1:0]      cyc_idx;
  logic [`SNPRW_SNOOP_DELAY-2:0] external_addr_strobe_n_pipe;
  snprw_word_t        snoop_addr_q;
  logic               hit_q;
  logic               dirty_q;
  logic               pend_wb;
  logic [IW-1:0]      pend_idx;
  logic               mode_wb;
  logic               reset_seen;
  logic               cache_q;

  function automatic logic [IW-1:0] line_index(input snprw_word_t a);
    line_index = a[4 +: IW];
  endfunction

  wire [IW-1:0] snoop_idx   = line_index(snoop_addr_q);
  wire          snoop_hit   = line_valid[snoop_idx] && line_tag[snoop_idx][31:4] == snoop_addr_q[31:4];
  wire          snoop_dirty = snoop_hit && line_dirty[snoop_idx] && mode_wb;
  wire          answer_now  = external_addr_strobe_n_pipe[`SNPRW_SNOOP_DELAY-2]; // Answer register is the last stage
  wire          floated     = BUS.bus_hold || !BUS.backoff_n;
  wire          ready_seen  = !BUS.burst_ready_n || !BUS.ready_n;
  wire          line_end    = beat == 2'(`SNPRW_LINE_BEATS - 1);
  wire          last_beat   = (wb_active && !burst_mode) || line_end; // Reads always run as one burst
  wire          start_ok    = state == SNPRW_IDLE && !floated;
  wire          start_wb    = start_ok && (pend_wb || (REPLACE_REQ && mode_wb));
  wire          start_rd    = start_ok && !start_wb && READ_REQ;
  // Cache indicator only on cacheable unlocked reads or writebacks
  wire          next_cache  = wb_active || (rd_active && !rd_uncached && !rd_locked);

  // Strap caught on the first clock after reset release
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      reset_seen <= 1'b0;
      mode_wb    <= 1'b0;
    end else if (!reset_seen) begin
      reset_seen <= 1'b1;
      mode_wb    <= BUS.writeback_mode_select;
    end
  end

  // Burst select sampled at each writeback start, and only in write-back mode
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      burst_mode <= 1'b0;
    end else if (start_wb && mode_wb) begin
      burst_mode <= !BUS.burst_writeback_select_n;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      external_addr_strobe_n_pipe    <= '0;
      snoop_addr_q <= '0;
    end else begin
      external_addr_strobe_n_pipe <= (`SNPRW_SNOOP_DELAY-1)'({external_addr_strobe_n_pipe, !BUS.external_addr_strobe_n});
      if (!BUS.external_addr_strobe_n) begin
        snoop_addr_q <= BUS.snoop_addr;
      end
    end
  end

  // Answer lands exactly two clocks after the strobe; hit holds until the next, dirty drops earlier
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hit_q    <= 1'b0;
      dirty_q  <= 1'b0;
      pend_wb  <= 1'b0;
      pend_idx <= '0;
    end else if (answer_now) begin
      hit_q    <= snoop_hit;
      dirty_q  <= snoop_dirty;
      pend_wb  <= snoop_dirty && !INVALIDATE_REQ;
      pend_idx <= snoop_idx;
    end else begin
      if (start_wb) begin
        pend_wb <= 1'b0;
      end
      // Drop after the final ready, so it is gone before any next strobe
      if ((wb_snoop && state == SNPRW_DATA && ready_seen && line_end) || (dirty_q && !pend_wb && !wb_snoop)) begin
        dirty_q <= 1'b0;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SNPRW_IDLE: begin
        if (start_wb || start_rd) next_state = SNPRW_ADDR;
      end
      SNPRW_ADDR: begin
        next_state = SNPRW_DATA;
      end
      SNPRW_DATA: begin
        if (ready_seen && line_end) next_state = SNPRW_DONE;
        else if (ready_seen && last_beat && wb_active) next_state = SNPRW_NEXT;
      end
      SNPRW_NEXT: begin
        if (!floated) next_state = SNPRW_ADDR;
      end
      SNPRW_DONE: begin
        next_state = SNPRW_IDLE;
      end
      default: next_state = SNPRW_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= SNPRW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wb_active   <= 1'b0;
      wb_snoop    <= 1'b0;
      rd_active   <= 1'b0;
      rd_uncached <= 1'b0;
      rd_locked   <= 1'b0;
      cyc_addr    <= '0;
      cyc_idx     <= '0;
      beat        <= '0;
    end else if (start_wb) begin
      wb_active <= 1'b1;
      wb_snoop  <= pend_wb;
      cyc_idx   <= pend_wb ? pend_idx : line_index(REPLACE_ADDR);
      cyc_addr  <= pend_wb ? {snoop_addr_q[31:4], 4'h0} : {REPLACE_ADDR[31:4], 4'h0};
      beat      <= '0;
    end else if (start_rd) begin
      rd_active   <= 1'b1;
      rd_uncached <= READ_UNCACHED;
      rd_locked   <= READ_LOCKED;
      cyc_idx     <= line_index(READ_ADDR);
      cyc_addr    <= {READ_ADDR[31:4], 4'h0};
      beat        <= '0;
    end else if (state == SNPRW_DATA && ready_seen) begin
      beat <= beat + 2'h1;
    end else if (state == SNPRW_DONE) begin
      wb_active <= 1'b0;
      wb_snoop  <= 1'b0;
      rd_active <= 1'b0;
    end
  end

  // Indicator held from the strobe to the first ready; negated after
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cache_q <= 1'b0;
    end else if (state == SNPRW_ADDR) begin
      cache_q <= next_cache;
    end else if (ready_seen) begin
      cache_q <= 1'b0;
    end
  end

  // Cache array: fills on cacheable reads, cleaned by writebacks
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      line_valid <= '0;
      line_dirty <= '0;
    end else begin
      if (rd_active && !rd_uncached && state == SNPRW_DATA && ready_seen) begin
        line_word[cyc_idx][beat] <= BUS.read_data;
        line_tag[cyc_idx]        <= cyc_addr;
        if (line_end) line_valid[cyc_idx] <= 1'b1;
        line_dirty[cyc_idx] <= mode_wb;
      end
      if (wb_active && state == SNPRW_DONE) begin
        line_dirty[cyc_idx] <= 1'b0;
      end
      if (INVALIDATE_REQ) begin
        line_valid <= '0;
        line_dirty <= '0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      READ_DATA <= '0;
    end else if (rd_active && state == SNPRW_DATA && ready_seen) begin
      READ_DATA <= BUS.read_data;
    end
  end

  assign REQ_READY      = state == SNPRW_IDLE && !floated && !pend_wb;
  assign WRITEBACK_MODE = mode_wb;

  assign BUS.snoop_hit_n            = !hit_q;
  assign BUS.snoop_match_dirty_n    = !dirty_q;
  assign BUS.hold_acknowledge       = BUS.bus_hold;
  assign BUS.bus_request_out        = start_wb || start_rd || (state != SNPRW_IDLE);
  assign BUS.address_strobe_n       = !(state == SNPRW_ADDR);
  assign BUS.address_strobe_oe      = !floated;
  assign BUS.last_transfer_n        = !(state == SNPRW_DATA && last_beat);
  assign BUS.last_transfer_oe       = !floated;
  assign BUS.cache_cycle_n          = !(state == SNPRW_ADDR ? next_cache : cache_q);
  assign BUS.cache_cycle_oe         = !floated;
  assign BUS.write_n_read           = wb_active;
  assign BUS.pseudo_lock_n          = !(rd_active && rd_locked);
  assign BUS.page_uncached_attr     = rd_active && rd_uncached;
  assign BUS.page_writethrough_attr = !mode_wb;
  assign BUS.byte_enables_n         = 4'h0;
  assign BUS.ctrl_oe                = !floated;
  assign BUS.upper_address          = cyc_addr[31:2];
  assign BUS.low_address_bits       = beat;
  assign BUS.low_address_oe         = !floated && !BUS.address_hold;
  assign BUS.write_data             = line_word[cyc_idx][beat];
endmodule

// ---- hw/snprw_system.sv ----
`timescale 1ns/1ps
`include "snprw_defs.svh"
module snprw_system (
  input  wire logic                   CLK,
  input  wire logic                   RESETN,
  snprw_bus_if.system                 BUS,
  input  wire logic                   SNOOP_REQ,
  input  wire snprw_pkg::snprw_word_t SNOOP_ADDR,
  input  wire logic                   HOLD_REQ,
  input  wire logic                   BACKOFF_REQ,
  input  wire logic                   AHOLD_REQ,
  input  wire logic                   BURST_STRAP_N,
  input  wire logic                   MODE_STRAP,
  input  wire snprw_pkg::snprw_word_t MEM_DATA,
  output logic                        MASTER_BLOCK,
  output logic                        REPLACE_WB_SEEN,
  output logic                        SNOOP_WB_SEEN,
  output logic                        SNOOP_HIT,
  output snprw_pkg::snprw_word_t      WB_DATA
);
  import snprw_pkg::*;

  logic in_cycle;

  // Snoop strobe follows SNOOP_REQ directly, with no check for own cycles
  assign BUS.external_addr_strobe_n  = !SNOOP_REQ;
  assign BUS.snoop_addr              = SNOOP_ADDR;
  assign BUS.address_hold            = AHOLD_REQ;
  assign BUS.bus_hold                = HOLD_REQ;
  assign BUS.backoff_n               = !BACKOFF_REQ;
  assign BUS.burst_writeback_select_n = BURST_STRAP_N;
  assign BUS.writeback_mode_select   = MODE_STRAP;
  assign BUS.read_data               = MEM_DATA;
  // Zero-wait memory: answer every data clock of the device's cycle
  assign BUS.burst_ready_n           = !(in_cycle && BUS.address_strobe_n);
  assign BUS.ready_n                 = 1'b1;

  wire strobe     = !BUS.address_strobe_n && BUS.address_strobe_oe;
  wire cache_on   = !BUS.cache_cycle_n && BUS.cache_cycle_oe;
  wire dirty_seen = !BUS.snoop_match_dirty_n;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      in_cycle <= 1'b0;
    end else if (strobe) begin
      in_cycle <= 1'b1;
    end else if (!BUS.last_transfer_n && !BUS.burst_ready_n) begin
      in_cycle <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REPLACE_WB_SEEN <= 1'b0;
      SNOOP_WB_SEEN   <= 1'b0;
      SNOOP_HIT       <= 1'b0;
      WB_DATA         <= '0;
    end else begin
      REPLACE_WB_SEEN <= strobe && BUS.write_n_read && cache_on && !dirty_seen;
      SNOOP_WB_SEEN   <= strobe && BUS.write_n_read && cache_on && dirty_seen;
      SNOOP_HIT       <= !BUS.snoop_hit_n;
      if (in_cycle && BUS.write_n_read && !BUS.burst_ready_n) begin
        WB_DATA <= BUS.write_data;
      end
    end
  end

  // Dirty pulses without a writeback are tolerated: block only while asserted
  assign MASTER_BLOCK = dirty_seen;
endmodule

// ---- tb/snprw_monitor.sv ----
`timescale 1ns/1ps
module snprw_monitor (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic external_addr_strobe_n,
  input wire logic snoop_hit_n,
  input wire logic snoop_match_dirty_n,
  input wire logic hold_acknowledge,
  input wire logic backoff_n,
  input wire logic address_hold,
  input wire logic address_strobe_n,
  input wire logic address_strobe_oe,
  input wire logic last_transfer_oe,
  input wire logic cache_cycle_n,
  input wire logic cache_cycle_oe,
  input wire logic write_n_read,
  input wire logic pseudo_lock_n,
  input wire logic page_uncached_attr,
  input wire logic ctrl_oe,
  input wire logic low_address_oe
);
  logic seen_snoop;
  wire  ads_on = !address_strobe_n && address_strobe_oe;

  default clocking mon_cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Cleared by reset only: the quiet check covers the span before any snoop
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      seen_snoop <= 1'b0;
    end else if (!external_addr_strobe_n) begin
      seen_snoop <= 1'b1;
    end
  end

  hit_timing_a: assert property ($changed(snoop_hit_n) |-> !$past(external_addr_strobe_n, 2))
    else $error("hit output moved without a snoop two clocks before");
  dirty_timing_a: assert property ($fell(snoop_match_dirty_n) |-> !$past(external_addr_strobe_n, 2) && !snoop_hit_n)
    else $error("dirty output rose without a hitting snoop two clocks before");
  dirty_release_a: assert property ($fell(snoop_match_dirty_n) |-> ##[1:60] snoop_match_dirty_n)
    else $error("dirty output never released");
  dirty_strobe_a: assert property (ads_on && !snoop_match_dirty_n |-> write_n_read && !cache_cycle_n)
    else $error("non writeback strobe while dirty output asserted");
  write_cache_a: assert property (ads_on && write_n_read |-> !cache_cycle_n && cache_cycle_oe)
    else $error("write strobe without cache mark");
  read_cache_a: assert property (ads_on && !write_n_read |-> cache_cycle_n == (page_uncached_attr || !pseudo_lock_n))
    else $error("read cache mark wrong");
  float_ctrl_a: assert property (hold_acknowledge || (!backoff_n && !$past(backoff_n))
    |-> !ctrl_oe && !address_strobe_oe && !last_transfer_oe && !cache_cycle_oe)
    else $error("control outputs driven in hold or backoff");
  float_low_a: assert property (address_hold && $past(address_hold) |-> !low_address_oe)
    else $error("low address driven in address hold");
  quiet_reset_a: assert property (!seen_snoop |-> snoop_hit_n && snoop_match_dirty_n)
    else $error("snoop outputs active before any snoop");

  cover property (ads_on && write_n_read && !snoop_match_dirty_n);
  cover property (ads_on && write_n_read && snoop_match_dirty_n);
  cover property (ads_on && !write_n_read && !cache_cycle_n);
  cover property (hold_acknowledge && !ctrl_oe);
endmodule

// ---- tb/snoop_response_writeback_signals_test.sv ----
`timescale 1ns/1ps
`include "snprw_defs.svh"
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module snoop_response_writeback_signals_test;
  import snprw_pkg::*;
  logic        clk, resetn, mode, burst_n, inv, repl, rd, unc, lck, snp, hold, boff, ahold;
  logic        req_ready, wb_mode, master_block, rwb_seen, swb_seen, snoop_hit;
  snprw_word_t raddr, paddr, saddr, mdata, read_data, wb_data;
  int          mismatches, comparisons, n_ads, n_last, n_rdy, n_swb, n_rwb;

  snprw_bus_if bus ();
  snprw_device snprw_device_inst (.CLK(clk), .RESETN(resetn), .BUS(bus.device),
    .INVALIDATE_REQ(inv), .REPLACE_REQ(repl), .REPLACE_ADDR(paddr), .READ_REQ(rd), .READ_ADDR(raddr),
    .READ_UNCACHED(unc), .READ_LOCKED(lck), .REQ_READY(req_ready), .WRITEBACK_MODE(wb_mode), .READ_DATA(read_data));
  snprw_system snprw_system_inst (.CLK(clk), .RESETN(resetn), .BUS(bus.system), .SNOOP_REQ(snp),
    .SNOOP_ADDR(saddr), .HOLD_REQ(hold), .BACKOFF_REQ(boff), .AHOLD_REQ(ahold), .BURST_STRAP_N(burst_n),
    .MODE_STRAP(mode), .MEM_DATA(mdata), .MASTER_BLOCK(master_block), .REPLACE_WB_SEEN(rwb_seen),
    .SNOOP_WB_SEEN(swb_seen), .SNOOP_HIT(snoop_hit), .WB_DATA(wb_data));
  snprw_monitor snprw_monitor_inst (.CLK(clk), .RESETN(resetn),
    .external_addr_strobe_n(bus.external_addr_strobe_n), .snoop_hit_n(bus.snoop_hit_n),
    .snoop_match_dirty_n(bus.snoop_match_dirty_n), .hold_acknowledge(bus.hold_acknowledge),
    .backoff_n(bus.backoff_n), .address_hold(bus.address_hold), .address_strobe_n(bus.address_strobe_n),
    .address_strobe_oe(bus.address_strobe_oe), .last_transfer_oe(bus.last_transfer_oe),
    .cache_cycle_n(bus.cache_cycle_n), .cache_cycle_oe(bus.cache_cycle_oe), .write_n_read(bus.write_n_read),
    .pseudo_lock_n(bus.pseudo_lock_n), .page_uncached_attr(bus.page_uncached_attr), .ctrl_oe(bus.ctrl_oe),
    .low_address_oe(bus.low_address_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Reads raise ready too, so the tallies are cleared just before each writeback
  always @(posedge clk) begin
    if (!bus.address_strobe_n && bus.address_strobe_oe) n_ads++;
    if (!bus.last_transfer_n && bus.last_transfer_oe && !(bus.burst_ready_n && bus.ready_n)) n_last++;
    if (!(bus.burst_ready_n && bus.ready_n)) n_rdy++;
    n_swb += swb_seen;
    n_rwb += rwb_seen;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset(input logic m, input logic b);
    @(negedge clk);
    resetn = 1'b0;
    mode = m;
    burst_n = b;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    `CHECK("mode", m, wb_mode)
    `CHECK("snoop idle", 2'b11, {bus.snoop_hit_n, bus.snoop_match_dirty_n})
  endtask

  task automatic do_read(input snprw_word_t a, input logic u, input logic l);
    @(negedge clk);
    raddr = a;
    unc = u;
    lck = l;
    rd = 1'b1;
    for (int k = 0; k < 50 && !req_ready; k++) @(negedge clk);
    @(negedge clk);
    rd = 1'b0;
    `CHECK("read strobe", 1'b0, bus.address_strobe_n)
    `CHECK("bus request", 1'b1, bus.bus_request_out)
    `CHECK("read cache mark", u | l, bus.cache_cycle_n)
    for (int k = 0; k < 50 && !req_ready; k++) @(negedge clk);
    `CHECK("read data", mdata, read_data)
  endtask

  task automatic snoop(input snprw_word_t a, input logic i, input logic eh, input logic ed);
    int k;
    @(negedge clk);
    {n_ads, n_last, n_rdy, n_swb, n_rwb} = '0;
    saddr = a;
    snp = 1'b1;
    fork
      begin
        @(negedge clk);
        snp = 1'b0;
      end
    join_none
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus.external_addr_strobe_n !== 1'b0 && k < 10);
    @(negedge clk);
    inv = i;
    @(posedge clk);
    #1;
    if (!i) begin
      `CHECK("hit answer", !eh, bus.snoop_hit_n)
      `CHECK("dirty answer", !ed, bus.snoop_match_dirty_n)
      `CHECK("master block", ed, master_block)
    end
    @(negedge clk);
    inv = 1'b0;
    @(negedge clk);
    `CHECK("system hit", eh, snoop_hit)
  endtask

  task automatic replace(input snprw_word_t a);
    @(negedge clk);
    {n_ads, n_last, n_rdy, n_swb, n_rwb} = '0;
    paddr = a;
    repl = 1'b1;
    for (int k = 0; k < 50 && !req_ready; k++) @(negedge clk);
    @(negedge clk);
    repl = 1'b0;
  endtask

  task automatic wb_wait(input int ads, input logic sw, input logic rw);
    repeat (8) @(negedge clk);
    for (int k = 0; k < 80 && !(req_ready && bus.snoop_match_dirty_n); k++) @(negedge clk);
    `CHECK("strobes", ads, n_ads)
    `CHECK("last marks", ads, n_last)
    `CHECK("beats", (ads > 0) ? `SNPRW_LINE_BEATS : 0, n_rdy)
    `CHECK("snoop wb start", sw, n_swb > 0)
    `CHECK("replace wb start", rw, n_rwb > 0)
    if (ads > 0) `CHECK("wb data", mdata, wb_data)
  endtask

  initial begin
    {resetn, mode, burst_n, inv, repl, rd, unc, lck, snp, hold, boff, ahold} = '0;
    {raddr, paddr, saddr} = '0;
    mdata = 32'h5A3C96E1;
    do_reset(1'b1, 1'b0);
    for (int c = 0; c < 4; c++) do_read(32'h00, c[0], c[1]);
    $display("test read marks done");
    do_read(32'h10, 1'b0, 1'b0);
    snoop(32'h20, 1'b0, 1'b0, 1'b0);
    snoop(32'h10, 1'b0, 1'b1, 1'b1);
    wb_wait(1, 1'b1, 1'b0);
    do_read(32'h30, 1'b0, 1'b0);
    replace(32'h30);
    wb_wait(1, 1'b0, 1'b1);
    $display("test burst writebacks done");
    do_read(32'h10, 1'b0, 1'b0);
    snoop(32'h10, 1'b1, 1'b1, 1'b1);
    wb_wait(0, 1'b0, 1'b0);
    $display("test invalidate during snoop done");
    for (int s = 0; s < 3; s++) begin
      @(negedge clk);
      hold = (s == 0);
      boff = (s == 1);
      ahold = (s == 2);
      repeat (6) @(negedge clk);
      `CHECK("control enable", s == 2, bus.ctrl_oe)
      `CHECK("low address enable", 1'b0, bus.low_address_oe)
      `CHECK("hold answer", s == 0, bus.hold_acknowledge)
      {hold, boff, ahold} = '0;
      repeat (6) @(negedge clk);
    end
    $display("test floating done");
    // Straps move only while reset is held
    do_reset(1'b0, 1'b0);
    do_read(32'h10, 1'b0, 1'b0);
    snoop(32'h10, 1'b0, 1'b1, 1'b0);
    replace(32'h10);
    wb_wait(0, 1'b0, 1'b0);
    $display("test write-through mode done");
    do_reset(1'b1, 1'b1);
    do_read(32'h10, 1'b0, 1'b0);
    snoop(32'h10, 1'b0, 1'b1, 1'b1);
    wb_wait(`SNPRW_LINE_BEATS, 1'b1, 1'b0);
    $display("test single writebacks done");
    final_report();
  end

  // The sequence needs a few hundred clocks; this allows well over ten times that
  initial begin
    #60000;
    mismatches++;
    final_report();
  end
endmodule
